// *** src/compat_audio_window.sv ***
// Legacy game-audio compatible I/O window: decode, FM pass-through, reset, mixer and command path
//
// Overview of operation
// - Offset 4 write sets the mixer index
// - Offset 5 accesses the indexed mixer register
// - FM status/select and data ports decoded
// - Offset 6 bit0 one-then-zero resets interface
// - Read data valid while offset E bit7
// - Commands written at offset C are accepted only while ready
// - Offset C bit7 reads command ready
// - Mixer registers shadow the native mixer
// - Index 00H write restores mixer defaults
// - Index 04H voice level, reset 99H
// - Index 0AH mic mix, reset 01H
// - Index 0CH bits 2:1 pick capture source
// - Index 0EH bit1 picks mono or stereo
// - Index 22H master level, reset 99H
// - Index 26H synth level, reset 99H
// - Index 28H disc level, reset 01H
// - Index 2EH line-in level, reset 01H
// - Sixteen ports, ten-bit decode, no aliasing
// - FM writes and status/select-port reads forwarded to external synthesizer
`timescale 1ns/1ps
`include "compat_window_params.svh"
module compat_audio_window #(
	parameter int ADDR_W = 16,
	parameter int CONSUME_CYC = `CMD_CONSUME_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] io_addr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic io_hit,
	input wire logic [9:0] compat_window_base,
	input wire logic compat_active,
	output logic fm_wr,
	output logic fm_rd,
	output logic [1:0] fm_addr,
	output logic fm_bank,
	output logic [7:0] fm_wdata,
	input wire logic [7:0] fm_rdata,
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	input wire logic result_valid,
	input wire logic [7:0] result_data,
	output logic result_ready,
	output logic interface_reset,
	output logic codec_native_enable,
	output logic [7:0] voice_level,
	output logic [7:0] mic_mix_level,
	output compat_window_pkg::capture_src_t capture_source,
	output logic stereo_output_select,
	output logic [7:0] master_level,
	output logic [7:0] synth_level,
	output logic [7:0] disc_audio_level,
	output logic [7:0] line_in_level
);
	// Narrower buses cannot carry the ten-bit decode
	generate
		if (ADDR_W < 10) begin : g_bad_addr_w
			$error("ADDR_W must cover ten-bit decode");
		end
	endgenerate
	logic upper_zero;
	logic base_match;
	logic [3:0] ofs;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] mixer_index;
	logic soft_bit;
	logic soft_pulse;
	logic [7:0] mixer_rdata;
	logic cmd_ready;
	logic data_avail;
	logic [7:0] read_data;
	logic [7:0] fm_status;

	// Upper bits must be zero so the window never aliases
	generate
		if (ADDR_W > 10) begin : g_upper
			assign upper_zero = io_addr[ADDR_W-1:10] == '0;
		end else begin : g_noupper
			assign upper_zero = 1'b1;
		end
	endgenerate
	assign base_match = upper_zero && io_addr[9:4] == compat_window_base[9:4];
	assign ofs = io_addr[3:0];
	assign wr_hit = base_match && io_wr;
	assign rd_hit = base_match && io_rd;
	assign io_hit = base_match && (io_rd || io_wr);

	// Index latch; host must load it before data-port access
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			mixer_index <= 8'h00;
		else if (soft_pulse)
			mixer_index <= 8'h00;
		else if (wr_hit && ofs == `OFS_MIXER_INDEX)
			mixer_index <= io_wdata;
	end

	// Reset fires on the falling edge of the written bit, so a stuck one holds nothing
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			soft_bit <= 1'b0;
			soft_pulse <= 1'b0;
		end else begin
			soft_pulse <= 1'b0;
			if (wr_hit && ofs == `OFS_SOFT_RESET) begin
				soft_bit <= io_wdata[`BIT_SOFT_RESET];
				soft_pulse <= soft_bit && !io_wdata[`BIT_SOFT_RESET];
			end
		end
	end
	assign interface_reset = soft_pulse;

	// FM ports pass straight through; bank picks right pair
	always_comb begin
		fm_wr = 1'b0;
		fm_rd = 1'b0;
		fm_addr = 2'h0;
		fm_bank = 1'b0;
		fm_wdata = io_wdata;
		if (ofs == `OFS_FM_LEFT_SEL || ofs == `OFS_FM_LEFT_DATA) begin
			fm_addr = {1'b0, ofs[0]};
			fm_wr = wr_hit;
			fm_rd = rd_hit && ofs == `OFS_FM_LEFT_SEL;
		end else if (ofs == `OFS_FM_RIGHT_SEL || ofs == `OFS_FM_RIGHT_DATA) begin
			fm_addr = {1'b0, ofs[0]};
			fm_bank = 1'b1;
			fm_wr = wr_hit;
			fm_rd = rd_hit && ofs == `OFS_FM_RIGHT_SEL;
		end else if (ofs == `OFS_FM_PAIR_SEL || ofs == `OFS_FM_PAIR_DATA) begin
			fm_addr = {1'b1, ofs[0]};
			fm_wr = wr_hit;
			fm_rd = rd_hit && ofs == `OFS_FM_PAIR_SEL;
		end
	end
	assign fm_status = fm_rdata;

	compat_mixer_shadow u_mixer (
		.clk(clk),
		.arst_n(arst_n),
		.soft_clear(soft_pulse),
		.wr_en(wr_hit && ofs == `OFS_MIXER_DATA),
		.index(mixer_index),
		.wr_data(io_wdata),
		.rd_data(mixer_rdata),
		.voice_level(voice_level),
		.mic_mix_level(mic_mix_level),
		.capture_source(capture_source),
		.stereo_output_select(stereo_output_select),
		.master_level(master_level),
		.synth_level(synth_level),
		.disc_audio_level(disc_audio_level),
		.line_in_level(line_in_level)
	);

	compat_cmd_channel #(
		.CONSUME_CYC(CONSUME_CYC)
	) u_cmd (
		.clk(clk),
		.arst_n(arst_n),
		.soft_clear(soft_pulse),
		.cmd_wr(wr_hit && ofs == `OFS_COMMAND),
		.cmd_data(io_wdata),
		.data_rd(rd_hit && ofs == `OFS_READ_DATA),
		.cmd_ready(cmd_ready),
		.cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte),
		.result_valid(result_valid),
		.result_data(result_data),
		.result_ready(result_ready),
		.data_avail(data_avail),
		.read_data(read_data)
	);

	// Native codec path off while the compatibility mode is selected
	assign codec_native_enable = !compat_active;

	// Read mux; combinational so the host sees it within the I/O strobe
	always_comb begin
		io_rdata = 8'h00;
		if (!rd_hit)
			io_rdata = 8'h00;
		else if (ofs == `OFS_FM_LEFT_SEL || ofs == `OFS_FM_RIGHT_SEL || ofs == `OFS_FM_PAIR_SEL)
			io_rdata = fm_status;
		else if (ofs == `OFS_MIXER_DATA)
			io_rdata = mixer_rdata;
		else if (ofs == `OFS_READ_DATA)
			io_rdata = read_data;
		else if (ofs == `OFS_COMMAND)
			io_rdata = {cmd_ready, 7'h00};
		else if (ofs == `OFS_AVAIL_STATUS)
			io_rdata = {data_avail, 7'h00};
	end

	a_no_alias: assert property (@(posedge clk) disable iff (!arst_n)
		io_hit |-> (io_addr >> 10) == '0 && io_addr[9:4] == compat_window_base[9:4])
		else $error("decode aliased");
	a_index_load: assert property (@(posedge clk) disable iff (!arst_n)
		wr_hit && ofs == `OFS_MIXER_INDEX && !soft_pulse |=> mixer_index == $past(io_wdata))
		else $error("index not loaded");
	a_soft_reset: assert property (@(posedge clk) disable iff (!arst_n)
		wr_hit && ofs == `OFS_SOFT_RESET && soft_bit && !io_wdata[`BIT_SOFT_RESET]
		|=> soft_pulse ##1 master_level == `RST_MASTER && mixer_index == 8'h00)
		else $error("soft reset missed");
	a_ready_read: assert property (@(posedge clk) disable iff (!arst_n)
		rd_hit && ofs == `OFS_COMMAND |-> io_rdata[`BIT_FLAG] == cmd_ready)
		else $error("ready bit wrong");
	a_avail_read: assert property (@(posedge clk) disable iff (!arst_n)
		rd_hit && ofs == `OFS_AVAIL_STATUS |-> io_rdata[`BIT_FLAG] == data_avail)
		else $error("available bit wrong");
	a_fm_forward: assert property (@(posedge clk) disable iff (!arst_n)
		wr_hit && ofs == `OFS_FM_PAIR_DATA |-> fm_wr && fm_addr == 2'h3)
		else $error("fm write not forwarded");
	c_mixer_write: cover property (@(posedge clk) wr_hit && ofs == `OFS_MIXER_DATA);
	c_soft_reset: cover property (@(posedge clk) soft_pulse);
	c_status_poll: cover property (@(posedge clk) rd_hit && ofs == `OFS_AVAIL_STATUS && data_avail);
endmodule : compat_audio_window

// *** src/compat_window_params.svh ***
// Offsets, field positions, reset values and timing counts of the compatibility window
`ifndef COMPAT_WINDOW_PARAMS_SVH
`define COMPAT_WINDOW_PARAMS_SVH
`define OFS_FM_LEFT_SEL 4'h0
`define OFS_FM_LEFT_DATA 4'h1
`define OFS_FM_RIGHT_SEL 4'h2
`define OFS_FM_RIGHT_DATA 4'h3
`define OFS_MIXER_INDEX 4'h4
`define OFS_MIXER_DATA 4'h5
`define OFS_SOFT_RESET 4'h6
`define OFS_FM_PAIR_SEL 4'h8
`define OFS_FM_PAIR_DATA 4'h9
`define OFS_READ_DATA 4'hA
`define OFS_COMMAND 4'hC
`define OFS_AVAIL_STATUS 4'hE
`define IDX_MIXER_DEFAULTS 8'h00
`define IDX_VOICE 8'h04
`define IDX_MIC 8'h0A
`define IDX_CAPTURE_SRC 8'h0C
`define IDX_OUTPUT_MODE 8'h0E
`define IDX_MASTER 8'h22
`define IDX_SYNTH 8'h26
`define IDX_DISC 8'h28
`define IDX_LINE_IN 8'h2E
`define RST_VOICE 8'h99
`define RST_MIC 8'h01
`define RST_CAPTURE_SRC 8'h00
`define RST_OUTPUT_MODE 8'h00
`define RST_MASTER 8'h99
`define RST_SYNTH 8'h99
`define RST_DISC 8'h01
`define RST_LINE_IN 8'h01
`define BIT_FLAG 7
`define BIT_SOFT_RESET 0
`define BIT_STEREO 1
`define MIC_LSB 0
`define MIC_MSB 2
`define SRC_LSB 1
`define SRC_MSB 2
`define CMD_CONSUME_NS 40
`define CMD_CONSUME_CYC ((`CMD_CONSUME_NS + 9) / 10)
`endif

// *** src/compat_window_pkg.sv ***
// Types shared by the compatibility window files
package compat_window_pkg;
	typedef enum logic [1:0] {
		SRC_MIC = 2'h0,
		SRC_DISC = 2'h1,
		SRC_LINE_IN = 2'h3
	} capture_src_t;
	typedef enum logic [1:0] {
		CMD_IDLE = 2'h0,
		CMD_BUSY = 2'h1,
		CMD_DONE = 2'h3
	} cmd_state_t;
endpackage : compat_window_pkg

// *** src/compat_mixer_shadow.sv ***
// Shadow mixer register bank with native mixer mapping
`timescale 1ns/1ps
`include "compat_window_params.svh"
module compat_mixer_shadow (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic soft_clear,
	input wire logic wr_en,
	input wire logic [7:0] index,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic [7:0] voice_level,
	output logic [7:0] mic_mix_level,
	output compat_window_pkg::capture_src_t capture_source,
	output logic stereo_output_select,
	output logic [7:0] master_level,
	output logic [7:0] synth_level,
	output logic [7:0] disc_audio_level,
	output logic [7:0] line_in_level
);
	localparam int N = 8;
	localparam logic [7:0] IDX [N] = '{`IDX_VOICE, `IDX_MIC, `IDX_CAPTURE_SRC, `IDX_OUTPUT_MODE,
		`IDX_MASTER, `IDX_SYNTH, `IDX_DISC, `IDX_LINE_IN};
	localparam logic [7:0] RST [N] = '{`RST_VOICE, `RST_MIC, `RST_CAPTURE_SRC, `RST_OUTPUT_MODE,
		`RST_MASTER, `RST_SYNTH, `RST_DISC, `RST_LINE_IN};
	logic [7:0] shadow [N];
	logic defaults_wr;
	assign defaults_wr = wr_en && index == `IDX_MIXER_DEFAULTS;
	// One shadow byte per mapped index
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_reg
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n)
					shadow[g] <= RST[g];
				else if (soft_clear || defaults_wr)
					shadow[g] <= RST[g];
				else if (wr_en && index == IDX[g])
					shadow[g] <= wr_data;
			end
		end
	endgenerate
	// Read mux; reserved or unmapped indexes read zero
	always_comb begin
		rd_data = 8'h00;
		for (int i = 0; i < N; i++) begin
			if (index == IDX[i])
				rd_data = shadow[i];
		end
	end
	// Native mixer view; nibbles carry left high, right low
	assign voice_level = shadow[0];
	assign mic_mix_level = {5'h00, shadow[1][`MIC_MSB:`MIC_LSB]};
	// Source code 2 aliases microphone
	assign capture_source = shadow[2][`SRC_MSB:`SRC_LSB] == 2'h2 ? compat_window_pkg::SRC_MIC
		: compat_window_pkg::capture_src_t'(shadow[2][`SRC_MSB:`SRC_LSB]);
	assign stereo_output_select = shadow[3][`BIT_STEREO];
	assign master_level = shadow[4];
	assign synth_level = shadow[5];
	assign disc_audio_level = shadow[6];
	assign line_in_level = shadow[7];

	a_defaults_restore: assert property (@(posedge clk) disable iff (!arst_n)
		defaults_wr |=> shadow[0] == `RST_VOICE && shadow[6] == `RST_DISC)
		else $error("mixer defaults not restored");
	a_master_write: assert property (@(posedge clk) disable iff (!arst_n)
		wr_en && index == `IDX_MASTER && !soft_clear |=> master_level == $past(wr_data))
		else $error("master level not written");
	a_src_alias: assert property (@(posedge clk) disable iff (!arst_n)
		wr_en && index == `IDX_CAPTURE_SRC && !soft_clear && wr_data[`SRC_MSB:`SRC_LSB] == 2'h2
		|=> capture_source == compat_window_pkg::SRC_MIC)
		else $error("source alias wrong");
endmodule : compat_mixer_shadow

// *** src/compat_cmd_channel.sv ***
// Command intake with ready flag and read-data holding register
`timescale 1ns/1ps
`include "compat_window_params.svh"
module compat_cmd_channel #(
	parameter int CONSUME_CYC = `CMD_CONSUME_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic soft_clear,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_data,
	input wire logic data_rd,
	output logic cmd_ready,
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	input wire logic result_valid,
	input wire logic [7:0] result_data,
	output logic result_ready,
	output logic data_avail,
	output logic [7:0] read_data
);
	// Counter is eight bits wide; zero would wrap and stay busy 256 cycles
	generate
		if (CONSUME_CYC < 1 || CONSUME_CYC > 255) begin : g_bad_consume
			$error("CONSUME_CYC out of range");
		end
	endgenerate
	compat_window_pkg::cmd_state_t state;
	logic [7:0] wait_cnt;
	// Ready drops at the write, returns once the handler took the byte
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= compat_window_pkg::CMD_IDLE;
			wait_cnt <= 8'h00;
			cmd_byte <= 8'h00;
		end else if (soft_clear) begin
			state <= compat_window_pkg::CMD_IDLE;
			wait_cnt <= 8'h00;
		end else begin
			case (state)
				compat_window_pkg::CMD_IDLE: begin
					if (cmd_wr) begin
						cmd_byte <= cmd_data;
						wait_cnt <= 8'(CONSUME_CYC);
						state <= compat_window_pkg::CMD_BUSY;
					end
				end
				compat_window_pkg::CMD_BUSY: begin
					if (wait_cnt == 8'h01)
						state <= compat_window_pkg::CMD_DONE;
					wait_cnt <= wait_cnt - 8'h01;
				end
				compat_window_pkg::CMD_DONE: begin
					state <= compat_window_pkg::CMD_IDLE;
				end
				default: begin
					state <= compat_window_pkg::CMD_IDLE;
				end
			endcase
		end
	end
	assign cmd_ready = state == compat_window_pkg::CMD_IDLE;
	assign cmd_valid = state == compat_window_pkg::CMD_DONE;
	// One-byte holding register; refills at the read if a byte is pending
	assign result_ready = !data_avail || data_rd;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_avail <= 1'b0;
			read_data <= 8'h00;
		end else if (soft_clear) begin
			data_avail <= 1'b0;
		end else if (result_valid && result_ready) begin
			data_avail <= 1'b1;
			read_data <= result_data;
		end else if (data_rd) begin
			data_avail <= 1'b0;
		end
	end

	a_ready_drops: assert property (@(posedge clk) disable iff (!arst_n)
		cmd_ready && cmd_wr && !soft_clear |=> !cmd_ready [*2])
		else $error("ready did not drop");
	a_ready_returns: assert property (@(posedge clk) disable iff (!arst_n)
		cmd_ready && cmd_wr |=> ##[1:260] cmd_ready)
		else $error("ready did not return");
	a_avail_clears: assert property (@(posedge clk) disable iff (!arst_n)
		data_rd && data_avail && !result_valid |=> !data_avail)
		else $error("available flag stuck");
	c_cmd_done: cover property (@(posedge clk) cmd_valid);
	c_refill: cover property (@(posedge clk) data_rd && result_valid && data_avail);
endmodule : compat_cmd_channel

// *** tb/host_bus_model.sv ***
// Host side model: byte accesses to the compatibility window
`timescale 1ns/1ps
module host_bus_model (
	input wire logic clk,
	input wire logic [9:0] base,
	output logic [15:0] io_addr,
	output logic io_rd,
	output logic io_wr,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata
);
	initial begin
		io_addr = 16'h0000;
		io_rd = 1'b0;
		io_wr = 1'b0;
		io_wdata = 8'h00;
	end
	// Strobe held over one rising edge; idle data inverted so no stale byte lingers
	task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		io_addr = a;
		io_wr = w;
		io_rd = !w;
		io_wdata = d;
		@(posedge clk);
		q = io_rdata;
		@(negedge clk);
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = ~d;
	endtask : acc
	task automatic wr(input logic [3:0] o, input logic [7:0] d);
		logic [7:0] q;
		acc({6'h00, base[9:4], o}, 1'b1, d, q);
	endtask : wr
	task automatic rd(input logic [3:0] o, output logic [7:0] q);
		acc({6'h00, base[9:4], o}, 1'b0, 8'h00, q);
	endtask : rd
	// Index always goes out before the data access
	task automatic mix_wr(input logic [7:0] i, input logic [7:0] d);
		wr(4'h4, i);
		wr(4'h5, d);
	endtask : mix_wr
	task automatic mix_rd(input logic [7:0] i, output logic [7:0] q);
		wr(4'h4, i);
		rd(4'h5, q);
	endtask : mix_rd
	// Bounded poll so a stuck flag cannot hang the host
	task automatic cmd(input logic [7:0] d);
		logic [7:0] s;
		int n;
		s = 8'h00;
		n = 0;
		while (s[7] !== 1'b1 && n < 40) begin
			rd(4'hC, s);
			n++;
		end
		wr(4'hC, d);
	endtask : cmd
endmodule : host_bus_model

// *** tb/tb_top.sv ***
// Self-checking bench for the compatibility window
`timescale 1ns/1ps
module tb_top;
	logic clk, arst_n, io_rd, io_wr, io_hit, compat_active, fm_wr, fm_rd, fm_bank, cmd_valid, hit_last;
	logic result_valid, result_ready, interface_reset, codec_native_enable, stereo_output_select;
	logic [15:0] io_addr;
	logic [9:0] base;
	logic [1:0] fm_addr;
	logic [10:0] fm_seen;
	logic [7:0] io_wdata, io_rdata, fm_wdata, fm_rdata, cmd_byte, cmd_last, result_data, q, v;
	logic [7:0] voice_level, mic_mix_level, master_level, synth_level, disc_audio_level, line_in_level;
	compat_window_pkg::capture_src_t capture_source;
	int err_count = 0, comparisons = 0, cyc = 0, irst_cnt = 0, cmd_cnt = 0, fm_rd_cnt = 0;
	int mix_m[int];
	int res_q[$];
	int idx_q[$] = '{4, 10, 12, 14, 34, 38, 40, 46};
	int dflt_q[$] = '{8'h99, 8'h01, 8'h00, 8'h00, 8'h99, 8'h99, 8'h01, 8'h01};
	logic [3:0] fm_ofs[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
	logic [2:0] fm_exp[6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h2, 3'h3};

	compat_audio_window #(.ADDR_W(16), .CONSUME_CYC(4)) compat_audio_window_inst (
		.clk(clk), .arst_n(arst_n), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .io_hit(io_hit), .compat_window_base(base), .compat_active(compat_active),
		.fm_wr(fm_wr), .fm_rd(fm_rd), .fm_addr(fm_addr), .fm_bank(fm_bank), .fm_wdata(fm_wdata),
		.fm_rdata(fm_rdata), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .result_valid(result_valid),
		.result_data(result_data), .result_ready(result_ready), .interface_reset(interface_reset),
		.codec_native_enable(codec_native_enable), .voice_level(voice_level), .mic_mix_level(mic_mix_level),
		.capture_source(capture_source), .stereo_output_select(stereo_output_select),
		.master_level(master_level), .synth_level(synth_level), .disc_audio_level(disc_audio_level),
		.line_in_level(line_in_level)
	);
	host_bus_model host_bus_model_inst (
		.clk(clk), .base(base), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
		.io_rdata(io_rdata)
	);

	initial clk = 1'b0;
	always #5 clk = ~clk;
	// One-cycle strobes are caught at the edge that samples them; cycle ceiling cuts hangs
	always @(posedge clk) begin
		cyc++;
		if (fm_wr === 1'b1) fm_seen <= {fm_bank, fm_addr, fm_wdata};
		if (fm_rd === 1'b1) fm_rd_cnt++;
		if (interface_reset === 1'b1) irst_cnt++;
		if (cmd_valid === 1'b1) begin
			cmd_cnt++;
			cmd_last <= cmd_byte;
		end
		if ((io_wr | io_rd) === 1'b1) hit_last <= io_hit;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic give_verdict();
		$display("TB: %0d compares, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic mdl_defaults();
		foreach (idx_q[k]) mix_m[idx_q[k]] = dflt_q[k];
	endtask : mdl_defaults
	// Only the documented bits of the sparse registers are compared
	function automatic logic [7:0] msk(int i);
		return (i == 10) ? 8'h07 : (i == 12) ? 8'h06 : (i == 14) ? 8'h02 : 8'hFF;
	endfunction : msk
	function automatic logic [1:0] src_of(int r);
		return (r[2:1] == 2'h3) ? 2'h3 : (r[2:1] == 2'h1) ? 2'h1 : 2'h0;
	endfunction : src_of
	task automatic check_all();
		logic [7:0] r;
		foreach (idx_q[k]) begin
			host_bus_model_inst.mix_rd(8'(idx_q[k]), r);
			chk("mixer read", r & msk(idx_q[k]), 8'(mix_m[idx_q[k]]) & msk(idx_q[k]));
		end
		chk("voice", voice_level, 8'(mix_m[4]));
		chk("mic", mic_mix_level, 8'(mix_m[10]) & 8'h07);
		chk("source", {6'h00, capture_source}, {6'h00, src_of(mix_m[12])});
		chk("stereo", {7'h00, stereo_output_select}, {7'h00, mix_m[14][1]});
		chk("master", master_level, 8'(mix_m[34]));
		chk("synth", synth_level, 8'(mix_m[38]));
		chk("disc", disc_audio_level, 8'(mix_m[40]));
		chk("line", line_in_level, 8'(mix_m[46]));
	endtask : check_all
	task automatic give_result(input logic [7:0] d);
		int n;
		logic ok;
		n = 0;
		ok = 1'b0;
		@(negedge clk);
		result_valid = 1'b1;
		result_data = d;
		do begin
			@(posedge clk);
			ok = result_ready;
			n++;
		end while (ok !== 1'b1 && n < 40);
		@(negedge clk);
		result_valid = 1'b0;
		result_data = ~d;
		chk("result taken", {7'h00, ok}, 8'h01);
	endtask : give_result
	task automatic wait_cmd(input int target);
		int n;
		n = 0;
		while (cmd_cnt < target && n < 40) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_cmd

	initial begin
		arst_n = 1'b0;
		base = 10'h220;
		compat_active = 1'b1;
		fm_rdata = 8'h00;
		result_valid = 1'b0;
		result_data = 8'h00;
		void'($urandom(32'h6F68));
		mdl_defaults();
		repeat (3) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		check_all();
		$display("test reset done");
		foreach (idx_q[k]) begin
			v = 8'($urandom);
			host_bus_model_inst.mix_wr(8'(idx_q[k]), v);
			mix_m[idx_q[k]] = v;
		end
		host_bus_model_inst.mix_wr(8'h06, 8'h5A);
		host_bus_model_inst.mix_rd(8'h06, q);
		chk("reserved index", q, 8'h00);
		check_all();
		// Every source code and both output modes, the aliased code included
		for (int s = 0; s < 4; s++) begin
			host_bus_model_inst.mix_wr(8'h0C, 8'(s << 1));
			host_bus_model_inst.mix_wr(8'h0E, 8'(s << 1));
			mix_m[12] = s << 1;
			mix_m[14] = s << 1;
			chk("source code", {6'h00, capture_source}, {6'h00, src_of(mix_m[12])});
			chk("mode bit", {7'h00, stereo_output_select}, {7'h00, mix_m[14][1]});
		end
		host_bus_model_inst.mix_wr(8'h00, 8'($urandom));
		mdl_defaults();
		check_all();
		$display("test mixer done");
		v = 8'($urandom);
		host_bus_model_inst.mix_wr(8'h22, v);
		mix_m[34] = v;
		chk("master set", master_level, v);
		host_bus_model_inst.wr(4'h6, 8'h01);
		chk("no pulse on set", 8'(irst_cnt), 8'h00);
		host_bus_model_inst.wr(4'h6, 8'h00);
		repeat (2) @(negedge clk);
		chk("soft pulse", 8'(irst_cnt), 8'h01);
		mdl_defaults();
		check_all();
		$display("test soft reset done");
		host_bus_model_inst.mix_wr(8'h22, 8'h35);
		mix_m[34] = 8'h35;
		host_bus_model_inst.acc({6'h01, base[9:4], 4'h5}, 1'b1, 8'hC3, q);
		chk("hit high bits", {7'h00, hit_last}, 8'h00);
		host_bus_model_inst.acc({6'h00, base[9:4] ^ 6'h01, 4'h5}, 1'b1, 8'hC3, q);
		chk("hit other base", {7'h00, hit_last}, 8'h00);
		host_bus_model_inst.rd(4'h7, q);
		chk("unmapped", q, 8'h00);
		chk("hit window", {7'h00, hit_last}, 8'h01);
		chk("master kept", master_level, 8'h35);
		$display("test decode done");
		foreach (fm_ofs[k]) begin
			v = 8'($urandom);
			host_bus_model_inst.wr(fm_ofs[k], v);
			chk("fm addr", {6'h00, fm_seen[9:8]}, {6'h00, fm_exp[k][1:0]});
			chk("fm data", fm_seen[7:0], v);
			if (k < 4) chk("fm bank", {7'h00, fm_seen[10]}, {7'h00, fm_exp[k][2]});
			if (fm_exp[k][0] == 1'b0) begin
				fm_rdata = 8'($urandom);
				host_bus_model_inst.rd(fm_ofs[k], q);
				chk("fm status", q, fm_rdata);
			end
		end
		chk("fm reads", 8'(fm_rd_cnt), 8'h03);
		$display("test fm done");
		v = 8'($urandom);
		host_bus_model_inst.wr(4'hC, v);
		host_bus_model_inst.wr(4'hC, ~v);
		host_bus_model_inst.rd(4'hC, q);
		chk("ready low", {7'h00, q[7]}, 8'h00);
		wait_cmd(1);
		host_bus_model_inst.rd(4'hC, q);
		chk("ready back", {7'h00, q[7]}, 8'h01);
		v = 8'($urandom);
		host_bus_model_inst.cmd(v);
		wait_cmd(2);
		repeat (2) @(negedge clk);
		chk("cmd count", 8'(cmd_cnt), 8'h02);
		chk("cmd byte", cmd_last, v);
		$display("test command done");
		repeat (3) begin
			v = 8'($urandom);
			res_q.push_back(v);
			give_result(v);
			host_bus_model_inst.rd(4'hE, q);
			chk("avail set", {7'h00, q[7]}, 8'h01);
			host_bus_model_inst.rd(4'hA, q);
			chk("read data", q, 8'(res_q.pop_front()));
			host_bus_model_inst.rd(4'hE, q);
			chk("avail clear", {7'h00, q[7]}, 8'h00);
		end
		// Second byte offered while the first waits; the read refills the holding register
		v = 8'($urandom);
		res_q.push_back(v);
		give_result(v);
		res_q.push_back(8'($urandom));
		@(negedge clk);
		result_valid = 1'b1;
		result_data = 8'(res_q[1]);
		host_bus_model_inst.rd(4'hA, q);
		result_valid = 1'b0;
		chk("refill first", q, 8'(res_q.pop_front()));
		host_bus_model_inst.rd(4'hE, q);
		chk("refill avail", {7'h00, q[7]}, 8'h01);
		host_bus_model_inst.rd(4'hA, q);
		chk("refill second", q, 8'(res_q.pop_front()));
		host_bus_model_inst.rd(4'hE, q);
		chk("refill drained", {7'h00, q[7]}, 8'h00);
		compat_active = 1'b0;
		@(negedge clk);
		chk("native on", {7'h00, codec_native_enable}, 8'h01);
		compat_active = 1'b1;
		@(negedge clk);
		chk("native off", {7'h00, codec_native_enable}, 8'h00);
		$display("test result and mode done");
		give_verdict();
	end
endmodule : tb_top
